// >>> ccc_compositor.sv
// Top of the colour channel compositor: pin synchronisers, pixel demux,
// APB register slave and three colour channels.
// Assumes pixel pins are asynchronous to pclk and an APB master on pclk.
`timescale 1ns/100ps
`default_nettype none

module ccc_compositor import ccc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pixel source pins
  input wire logic [PORTS-1:0][7:0] colour_input_ports,
  input wire logic [SLOTS-1:0][OVL_W-1:0] overlay_in,
  input wire logic [SLOTS-1:0] field_choice_input,
  input wire logic hsync_n,
  input wire logic vsync_n,
  input wire logic blank_n,
  // DAC side, one byte per dot slot
  output logic [SLOTS-1:0][7:0] dac_red,
  output logic [SLOTS-1:0][7:0] dac_green,
  output logic [SLOTS-1:0][7:0] dac_blue,
  output logic [SLOTS-1:0] dot_valid,
  output logic [2:0] dot_mux_factor,
  output logic sync_ped_off,
  output logic blank_ped_off
);

  // ==========================================================================
  // Pin synchronisers
  logic [PORTS-1:0][7:0] px_s1;
  logic [PORTS-1:0][7:0] px_s2;
  logic [SLOTS-1:0][OVL_W-1:0] ov_s1;
  logic [SLOTS-1:0][OVL_W-1:0] ov_s2;
  logic [SLOTS-1:0] fs_s1;
  logic [SLOTS-1:0] fs_s2;
  logic [2:0] ctl_s1;
  logic [2:0] ctl_s2;
  logic vs_s3_r;

  // Every pin passes two flops; the source keeps data steady per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      px_s1 <= '0;
      px_s2 <= '0;
      ov_s1 <= '0;
      ov_s2 <= '0;
      fs_s1 <= '0;
      fs_s2 <= '0;
      ctl_s1 <= 3'h7;
      ctl_s2 <= 3'h7;
      vs_s3_r <= 1'b1;
    end else begin
      px_s1 <= colour_input_ports;
      px_s2 <= px_s1;
      ov_s1 <= overlay_in;
      ov_s2 <= ov_s1;
      fs_s1 <= field_choice_input;
      fs_s2 <= fs_s1;
      ctl_s1 <= {hsync_n, vsync_n, blank_n};
      ctl_s2 <= ctl_s1;
      vs_s3_r <= ctl_s2[1];
    end
  end

  logic hs_s2;
  logic vs_s2;
  logic bl_s2;
  logic vs_rise;
  assign hs_s2 = ctl_s2[2];
  assign vs_s2 = ctl_s2[1];
  assign bl_s2 = ctl_s2[0];
  assign vs_rise = vs_s2 && !vs_s3_r;

  // ==========================================================================
  // Settings
  logic [4:0] mode_r;
  logic [4:0] mode_nxt;
  logic comp_r;
  logic comp_nxt;
  logic [7:0] pmask_r;
  logic [7:0] pmask_nxt;
  logic [OVL_W-1:0] omask_r;
  logic [OVL_W-1:0] omask_nxt;
  logic [4:0] dacctl_r;
  logic [4:0] dacctl_nxt;
  logic [1:0] size;
  logic [2:0] mux_raw;
  logic [2:0] mux_eff;
  ccc_field_e field;

  assign size = mode_r[MODE_SIZE_MSB:MODE_SIZE_LSB];
  assign mux_raw = mode_r[MODE_MUX_MSB:MODE_MUX_LSB];
  // Out-of-range factors clamp rather than stall the dot stream
  assign mux_eff = (mux_raw < MUX_MIN) ? MUX_MIN : (mux_raw > MUX_MAX) ? MUX_MAX : mux_raw;

  always_comb begin
    case (size)
      SIZE_16: field = CCC_F_RGB;
      SIZE_32: field = comp_r ? CCC_F_PIN : CCC_F_VALUE;
      default: field = CCC_F_PSEUDO;
    endcase
  end

  // ==========================================================================
  // Pixel demux
  logic [CHANS-1:0][SLOTS-1:0][7:0] slot_rgb;
  logic [SLOTS-1:0][7:0] slot_pse;
  logic [SLOTS-1:0] slot_on;
  logic is16;
  logic is32;
  assign is16 = (size == SIZE_16);
  assign is32 = (size == SIZE_32);

  for (genvar k = 0; k < SLOTS; k++) begin : g_demux
    logic [15:0] w16;
    logic [31:0] w32;
    assign w16 = {px_s2[2*k+1], px_s2[2*k]};
    assign w32 = {px_s2[4*k+3], px_s2[4*k+2], px_s2[4*k+1], px_s2[4*k]};
    assign slot_rgb[CH_R][k] = is32 ? w32[P32_R_MSB:P32_R_LSB] :
                               is16 ? {w16[P16_R_MSB:P16_R_LSB], 2'h0} : 8'h00;
    assign slot_rgb[CH_G][k] = is32 ? w32[P32_G_MSB:P32_G_LSB] :
                               is16 ? {w16[P16_G_MSB:P16_G_LSB], 2'h0} : 8'h00;
    assign slot_rgb[CH_B][k] = is32 ? w32[P32_B_MSB:P32_B_LSB] :
                               is16 ? {w16[P16_B_MSB:P16_B_LSB], 4'h0} : 8'h00;
    assign slot_pse[k] = is32 ? w32[P32_P_MSB:P32_P_LSB] : is16 ? 8'h00 : px_s2[k];
    assign slot_on[k] = (k < mux_eff);
  end

  // ==========================================================================
  // APB decode
  logic [1:0] region;
  logic [1:0] ch_sel;
  logic [7:0] tab_idx;
  logic [CHANS-1:0][7:0] tab_rd;
  logic [CHANS-1:0][CK_W-1:0] cksum;
  logic [31:0] rd_word;
  logic dec_err;
  logic wr_go;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic perr_r;
  logic perr_nxt;

  assign region = paddr[A_REG_MSB:A_REG_LSB];
  assign ch_sel = paddr[A_CH_MSB:A_CH_LSB];
  assign tab_idx = paddr[A_IDX_MSB:A_IDX_LSB];

  always_comb begin
    rd_word = 32'h0000_0000;
    dec_err = 1'b0;
    if (paddr[A_TOP_MSB:A_TOP_LSB] != 2'h0 || paddr[1:0] != 2'h0) begin
      dec_err = 1'b1;
    end else if (region == TAB_NONE) begin
      case (paddr[A_OFS_MSB:0])
        A_MODE: rd_word = {27'h0, mode_r};
        A_COMP: rd_word = {31'h0, comp_r};
        A_PMASK: rd_word = {24'h0, pmask_r};
        A_OMASK: rd_word = {30'h0, omask_r};
        A_DACCTL: rd_word = {27'h0, dacctl_r};
        A_CKSUM_R: rd_word = {8'h00, cksum[CH_R]};
        A_CKSUM_G: rd_word = {8'h00, cksum[CH_G]};
        A_CKSUM_B: rd_word = {8'h00, cksum[CH_B]};
        A_STATUS: rd_word = {29'h0, hs_s2, vs_s2, bl_s2};
        default: dec_err = 1'b1;
      endcase
    end else if (ch_sel >= CH_COUNT) begin
      dec_err = 1'b1;
    end else if (region == TAB_OVL && tab_idx >= OVL_LIMIT) begin
      dec_err = 1'b1;
    end else begin
      rd_word = {24'h0, tab_rd[ch_sel]};
    end
  end

  // Writes land only in the access phase, through byte lane 0
  assign wr_go = psel && penable && pwrite && pstrb[0] && !dec_err;

  always_comb begin
    mode_nxt = mode_r;
    comp_nxt = comp_r;
    pmask_nxt = pmask_r;
    omask_nxt = omask_r;
    dacctl_nxt = dacctl_r;
    if (wr_go && region == TAB_NONE) begin
      case (paddr[A_OFS_MSB:0])
        A_MODE: mode_nxt = pwdata[4:0];
        A_COMP: comp_nxt = pwdata[COMP_PIN_BIT];
        A_PMASK: pmask_nxt = pwdata[7:0];
        A_OMASK: omask_nxt = pwdata[OVL_W-1:0];
        A_DACCTL: dacctl_nxt = pwdata[4:0];
        default: mode_nxt = mode_r;
      endcase
    end
    // Read data is captured in setup so the access phase ends at once
    prdata_nxt = prdata_r;
    perr_nxt = perr_r;
    if (psel && !penable) begin
      prdata_nxt = pwrite ? 32'h0000_0000 : rd_word;
      perr_nxt = dec_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RST;
      comp_r <= 1'b0;
      pmask_r <= PMASK_RST;
      omask_r <= OMASK_RST;
      dacctl_r <= DACCTL_RST;
      prdata_r <= 32'h0000_0000;
      perr_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      comp_r <= comp_nxt;
      pmask_r <= pmask_nxt;
      omask_r <= omask_nxt;
      dacctl_r <= dacctl_nxt;
      prdata_r <= prdata_nxt;
      perr_r <= perr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && perr_r;

  // ==========================================================================
  // Colour channels
  logic [CHANS-1:0][SLOTS-1:0][7:0] dac_all;

  for (genvar c = 0; c < CHANS; c++) begin : g_chan
    ccc_channel u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .rgb_in(slot_rgb[c]),
      .pse_in(slot_pse),
      .ovl_in(ov_s2),
      .fsel_in(fs_s2),
      .slot_on(slot_on),
      .blank_n(bl_s2),
      .ck_clear(vs_rise),
      .field(field),
      .pse_mask(pmask_r),
      .ovl_mask(omask_r),
      .six_bit(dacctl_r[DC_SIX_BIT]),
      .intensity(dacctl_r[DC_INT_MSB:DC_INT_LSB]),
      .wr_en(wr_go && region != TAB_NONE && ch_sel == 2'(c)),
      .tab_sel(region),
      .tab_idx(tab_idx),
      .wr_data(pwdata[7:0]),
      .rd_data(tab_rd[c]),
      .dac_out(dac_all[c]),
      .cksum(cksum[c])
    );
  end

  assign dac_red = dac_all[CH_R];
  assign dac_green = dac_all[CH_G];
  assign dac_blue = dac_all[CH_B];

  // ==========================================================================
  // Dot rate and pedestal controls, aligned with the DAC bytes
  logic [SLOTS-1:0] dot_valid_r;
  logic [2:0] mux_r;
  logic sync_ped_r;
  logic blank_ped_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dot_valid_r <= '0;
      mux_r <= MUX_MIN;
      sync_ped_r <= 1'b0;
      blank_ped_r <= 1'b0;
    end else begin
      dot_valid_r <= slot_on;
      mux_r <= mux_eff;
      sync_ped_r <= dacctl_r[DC_SYNC_BIT] && (!hs_s2 || !vs_s2);
      blank_ped_r <= dacctl_r[DC_BLANK_BIT] && !bl_s2;
    end
  end

  assign dot_valid = dot_valid_r;
  assign dot_mux_factor = mux_r;
  assign sync_ped_off = sync_ped_r;
  assign blank_ped_off = blank_ped_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_blank_zero: assert property (!bl_s2 |=>
      dac_red == '0 && dac_green == '0 && dac_blue == '0)
    else $error("DAC not zero during blank");
  a_idle_slot: assert property (!slot_on[SLOTS-1] |=> dac_red[SLOTS-1] == 8'h00
      && !dot_valid[SLOTS-1])
    else $error("idle slot carried data");
  a_pin_latency: assert property (##2 px_s2 == $past(colour_input_ports, 2))
    else $error("pixel ports not sampled two clocks back");
  a_pmask_write: assert property (wr_go && region == TAB_NONE &&
      paddr[A_OFS_MSB:0] == A_PMASK |=> pmask_r == $past(pwdata[7:0]))
    else $error("pseudo mask write lost");
  a_pmask_read: assert property (psel && !penable && !pwrite &&
      paddr == {4'h0, A_PMASK} |=> prdata == {24'h0, $past(pmask_r)})
    else $error("pseudo mask read back wrong");
  a_zero_level: assert property (dacctl_r[DC_INT_MSB:DC_INT_LSB] == INT_ZERO &&
      $stable(dacctl_r) |=> dac_green == '0)
    else $error("zero intensity left DAC active");

  c_vsync_clear: cover property (vs_rise ##[1:20] bl_s2);
  c_overlay_hit: cover property (omask_r != '0 && (ov_s2[0] & omask_r) != '0 && bl_s2);
  c_pin_mode: cover property (is32 && comp_r && fs_s2[0] && bl_s2);
  c_table_write: cover property (wr_go && region == TAB_PSE);

endmodule

`default_nettype wire

// >>> ccc_pkg.sv
// Constants, address map and field layouts of the colour channel compositor.
// Assumes an APB master with 32-bit data and a 16-bit byte address.
package ccc_pkg;

  // ==========================================================================
  // Geometry
  localparam int SLOTS = 5;
  localparam int PORTS = 20;
  localparam int CHANS = 3;
  localparam int TAB_DEPTH = 256;
  localparam int OVL_DEPTH = 3;
  localparam int OVL_W = 2;
  localparam int CK_W = 24;
  localparam int CH_R = 0;
  localparam int CH_G = 1;
  localparam int CH_B = 2;

  // ==========================================================================
  // Address map
  localparam int A_TOP_MSB = 15;
  localparam int A_TOP_LSB = 14;
  localparam int A_REG_MSB = 13;
  localparam int A_REG_LSB = 12;
  localparam int A_CH_MSB = 11;
  localparam int A_CH_LSB = 10;
  localparam int A_IDX_MSB = 9;
  localparam int A_IDX_LSB = 2;
  localparam int A_OFS_MSB = 11;
  localparam logic [1:0] TAB_NONE = 2'h0;
  localparam logic [1:0] TAB_RGB = 2'h1;
  localparam logic [1:0] TAB_PSE = 2'h2;
  localparam logic [1:0] TAB_OVL = 2'h3;
  localparam logic [1:0] CH_COUNT = 2'h3;
  localparam logic [7:0] OVL_LIMIT = 8'h03;
  localparam logic [11:0] A_MODE = 12'h000;
  localparam logic [11:0] A_COMP = 12'h004;
  localparam logic [11:0] A_PMASK = 12'h008;
  localparam logic [11:0] A_OMASK = 12'h00C;
  localparam logic [11:0] A_DACCTL = 12'h010;
  localparam logic [11:0] A_CKSUM_R = 12'h014;
  localparam logic [11:0] A_CKSUM_G = 12'h018;
  localparam logic [11:0] A_CKSUM_B = 12'h01C;
  localparam logic [11:0] A_STATUS = 12'h020;

  // ==========================================================================
  // Register fields and reset values
  localparam int MODE_SIZE_MSB = 1;
  localparam int MODE_SIZE_LSB = 0;
  localparam int MODE_MUX_MSB = 4;
  localparam int MODE_MUX_LSB = 2;
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;
  localparam logic [2:0] MUX_MIN = 3'h2;
  localparam logic [2:0] MUX_MAX = 3'h5;
  localparam logic [4:0] MODE_RST = 5'h08;
  localparam logic [7:0] PMASK_RST = 8'hFF;
  localparam logic [1:0] OMASK_RST = 2'h0;
  localparam int COMP_PIN_BIT = 0;
  localparam int DC_SYNC_BIT = 0;
  localparam int DC_BLANK_BIT = 1;
  localparam int DC_SIX_BIT = 2;
  localparam int DC_INT_MSB = 4;
  localparam int DC_INT_LSB = 3;
  localparam logic [4:0] DACCTL_RST = 5'h00;
  localparam logic [1:0] INT_FULL = 2'h0;
  localparam logic [1:0] INT_HALF = 2'h1;
  localparam logic [1:0] INT_QUARTER = 2'h2;
  localparam logic [1:0] INT_ZERO = 2'h3;
  localparam logic [7:0] SIX_BIT_MASK = 8'hFC;

  // ==========================================================================
  // Pixel field layouts
  localparam int P16_R_MSB = 15;
  localparam int P16_R_LSB = 10;
  localparam int P16_G_MSB = 9;
  localparam int P16_G_LSB = 4;
  localparam int P16_B_MSB = 3;
  localparam int P16_B_LSB = 0;
  localparam int P32_R_MSB = 31;
  localparam int P32_R_LSB = 24;
  localparam int P32_G_MSB = 23;
  localparam int P32_G_LSB = 16;
  localparam int P32_B_MSB = 15;
  localparam int P32_B_LSB = 8;
  localparam int P32_P_MSB = 7;
  localparam int P32_P_LSB = 0;

  typedef enum logic [1:0] {CCC_F_RGB, CCC_F_PSEUDO, CCC_F_VALUE, CCC_F_PIN} ccc_field_e;

endpackage

// >>> ccc_channel.sv
// One colour channel: tables, masking, field and overlay selection,
// DAC data control and the dot checksum, for all slots in parallel.
// Assumes slot inputs already synchronised to pclk by the caller.
`timescale 1ns/100ps
`default_nettype none

module ccc_channel import ccc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Slot fields
  input wire logic [SLOTS-1:0][7:0] rgb_in,
  input wire logic [SLOTS-1:0][7:0] pse_in,
  input wire logic [SLOTS-1:0][OVL_W-1:0] ovl_in,
  input wire logic [SLOTS-1:0] fsel_in,
  input wire logic [SLOTS-1:0] slot_on,
  input wire logic blank_n,
  input wire logic ck_clear,
  // Settings
  input wire ccc_field_e field,
  input wire logic [7:0] pse_mask,
  input wire logic [OVL_W-1:0] ovl_mask,
  input wire logic six_bit,
  input wire logic [1:0] intensity,
  // Table access
  input wire logic wr_en,
  input wire logic [1:0] tab_sel,
  input wire logic [7:0] tab_idx,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // Results
  output logic [SLOTS-1:0][7:0] dac_out,
  output logic [CK_W-1:0] cksum
);

  // ==========================================================================
  // Tables
  // Left unreset: contents exist only once software writes them.
  logic [7:0] rgb_tab [TAB_DEPTH];
  logic [7:0] pse_tab [TAB_DEPTH];
  logic [7:0] ovl_tab [OVL_DEPTH];

  always_ff @(posedge pclk) begin
    if (wr_en && tab_sel == TAB_RGB) rgb_tab[tab_idx] <= wr_data;
    if (wr_en && tab_sel == TAB_PSE) pse_tab[tab_idx] <= wr_data;
    if (wr_en && tab_sel == TAB_OVL && tab_idx < OVL_LIMIT) ovl_tab[tab_idx[1:0]] <= wr_data;
  end

  always_comb begin
    case (tab_sel)
      TAB_RGB: rd_data = rgb_tab[tab_idx];
      TAB_PSE: rd_data = pse_tab[tab_idx];
      TAB_OVL: rd_data = (tab_idx < OVL_LIMIT) ? ovl_tab[tab_idx[1:0]] : 8'h00;
      default: rd_data = 8'h00;
    endcase
  end

  // ==========================================================================
  // Slot datapath
  function automatic logic [7:0] dac_scale(input logic [7:0] c, input logic six,
                                           input logic [1:0] lvl);
    logic [7:0] v;
    v = six ? (c & SIX_BIT_MASK) : c;
    case (lvl)
      INT_HALF: dac_scale = v >> 1;
      INT_QUARTER: dac_scale = v >> 2;
      INT_ZERO: dac_scale = 8'h00;
      default: dac_scale = v;
    endcase
  endfunction

  logic [SLOTS-1:0][7:0] masked;
  logic [SLOTS-1:0] pick_pse;
  logic [SLOTS-1:0][7:0] base;
  logic [SLOTS-1:0] ovl_hit;
  logic [SLOTS-1:0][7:0] dac_nxt;
  logic [SLOTS-1:0][7:0] dac_r;
  logic blank_q_r;
  logic [CK_W-1:0] sum_r;
  logic [CK_W-1:0] sum_nxt;
  logic [CK_W-1:0] total;

  for (genvar k = 0; k < SLOTS; k++) begin : g_slot
    logic [OVL_W-1:0] om;
    logic [7:0] col;
    assign masked[k] = pse_in[k] & pse_mask;
    assign pick_pse[k] = (field == CCC_F_PSEUDO) ? 1'b1 :
                         (field == CCC_F_VALUE) ? (masked[k] != 8'h00) :
                         (field == CCC_F_PIN) ? fsel_in[k] : 1'b0;
    assign base[k] = pick_pse[k] ? pse_tab[masked[k]] : rgb_tab[rgb_in[k]];
    assign om = ovl_in[k] & ovl_mask;
    assign ovl_hit[k] = (om != '0);
    assign col = ovl_hit[k] ? ovl_tab[om - 2'h1] : base[k];
    // Blank and idle slots beat every other source
    assign dac_nxt[k] = (!blank_n || !slot_on[k]) ? 8'h00 :
                        dac_scale(col, six_bit, intensity);
  end

  // Checksum taps the final DAC bytes, after every data stage
  always_comb begin
    total = '0;
    for (int i = 0; i < SLOTS; i++) begin
      total = total + {16'h0000, dac_r[i]};
    end
    if (ck_clear) begin
      sum_nxt = '0;
    end else if (blank_q_r) begin
      sum_nxt = sum_r + total;
    end else begin
      sum_nxt = sum_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_r <= '0;
      blank_q_r <= 1'b0;
      sum_r <= '0;
    end else begin
      dac_r <= dac_nxt;
      blank_q_r <= blank_n;
      sum_r <= sum_nxt;
    end
  end

  assign dac_out = dac_r;
  assign cksum = sum_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Case equality: unwritten table entries carry unknowns into the sum
  a_ck_clear: assert property (ck_clear |=> sum_r == '0)
    else $error("checksum not cleared after vsync rise");
  a_ck_accum: assert property (!ck_clear && blank_q_r |=>
      sum_r === $past(sum_r) + $past(total))
    else $error("checksum did not add the DAC bytes");
  a_ck_blank_hold: assert property (!ck_clear && !blank_q_r |=> sum_r === $past(sum_r))
    else $error("checksum moved during blanking");
  a_ovl_mask_off: assert property ((ovl_mask == '0) && blank_n && slot_on[0] && !six_bit
      && intensity == INT_FULL |=> dac_r[0] === $past(base[0]))
    else $error("overlay shown with zero overlay mask");
  a_value_pick: assert property (field == CCC_F_VALUE && masked[0] == 8'h00
      |-> !pick_pse[0])
    else $error("masked zero pseudo value did not pick RGB");

endmodule

`default_nettype wire

// >>> ccc_pixel_source.sv
// Pixel source model: frame buffer side, one new word on every pclk edge.
// Assumes the bench loads the next word by non-blocking assignment.
`timescale 1ns/100ps
`default_nettype none

module ccc_pixel_source import ccc_pkg::*; (
  // Clock
  input wire logic pclk,
  // Next word from the bench
  input wire logic [PORTS-1:0][7:0] pix_nxt,
  input wire logic [SLOTS-1:0][OVL_W-1:0] ovl_nxt,
  input wire logic [SLOTS-1:0] fsel_nxt,
  input wire logic [2:0] sync_nxt,
  // Pins toward the compositor
  output logic [PORTS-1:0][7:0] pix_r,
  output logic [SLOTS-1:0][OVL_W-1:0] ovl_r,
  output logic [SLOTS-1:0] fsel_r,
  output logic [2:0] sync_r
);
  // ==========================================================================
  // Word launch
  // Launched just after the edge, so the compositor sees it one edge later
  always_ff @(posedge pclk) begin
    pix_r <= pix_nxt;
    ovl_r <= ovl_nxt;
    fsel_r <= fsel_nxt;
    sync_r <= sync_nxt;
  end
endmodule

`default_nettype wire

// >>> ccc_compositor_tb_top.sv
// Bench of the compositor: APB set-up, table fill, pixel words, DAC bytes.
// Assumes the tables hold only what this bench writes into them.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED at %0t: got %h, expected %h", $time, a, b); end end

module ccc_compositor_tb_top import ccc_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, sync_ped_off, blank_ped_off, cp = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [PORTS-1:0][7:0] pix = '0, pix_p;
  logic [SLOTS-1:0][OVL_W-1:0] ov = '0, ov_p;
  logic [SLOTS-1:0] fs = '0, fs_p, dot_valid;
  logic [SLOTS-1:0][7:0] dac_red, dac_green, dac_blue;
  // Sync word is {hsync_n, vsync_n, blank_n}
  logic [2:0] sy = 3'h7, sy_p, dot_mux_factor, mx = 3'h2;
  logic [1:0] sz = SIZE_8, om = 2'h0;
  logic [4:0] dc = 5'h00;
  logic [7:0] pm = 8'hFF;
  int err_total = 0, n_compared = 0, cyc = 0, s[3];

  ccc_pixel_source src (.pclk(pclk), .pix_nxt(pix), .ovl_nxt(ov), .fsel_nxt(fs),
    .sync_nxt(sy), .pix_r(pix_p), .ovl_r(ov_p), .fsel_r(fs_p), .sync_r(sy_p));
  ccc_compositor uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .colour_input_ports(pix_p), .overlay_in(ov_p),
    .field_choice_input(fs_p), .hsync_n(sy_p[2]), .vsync_n(sy_p[1]), .blank_n(sy_p[0]),
    .dac_red(dac_red), .dac_green(dac_green), .dac_blue(dac_blue), .dot_valid(dot_valid),
    .dot_mux_factor(dot_mux_factor), .sync_ped_off(sync_ped_off),
    .blank_ped_off(blank_ped_off));

  // ==========================================================================
  // Clock and hang guard
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      finish_test();
    end
  end

  // ==========================================================================
  // APB master
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {24'h0, d}, q, e);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
    `CHK(e, xe)
  endtask
  task automatic cfg();
    wr({4'h0, A_MODE}, {3'h0, mx, sz});
    wr({4'h0, A_COMP}, {7'h0, cp});
    wr({4'h0, A_PMASK}, pm);
    wr({4'h0, A_OMASK}, {6'h0, om});
    wr({4'h0, A_DACCTL}, {3'h0, dc});
  endtask

  // ==========================================================================
  // Reference: table contents and one channel's DAC byte
  function automatic logic [15:0] ta(int r, int ch, int i);
    return 16'((r << 12) | (ch << 10) | (i << 2));
  endfunction
  function automatic logic [7:0] tv(int t, int ch, logic [7:0] i);
    return t == 1 ? ~i ^ 8'(ch) : t == 2 ? i + 8'(ch * 16) : 8'hA0 + 8'(ch * 4) + i;
  endfunction
  function automatic logic [7:0] mdl(int ch, int k);
    logic [15:0] w;
    logic [7:0] v, p, r;
    logic [1:0] o;
    w = {pix[2*k+1], pix[2*k]};
    p = (sz == SIZE_32 ? pix[4*k] : pix[k]) & pm;
    r = ch == 0 ? {w[15:10], 2'h0} : ch == 1 ? {w[9:4], 2'h0} : {w[3:0], 4'h0};
    if (sz == SIZE_32) r = pix[4*k+3-ch];
    if (sz == SIZE_16 || (sz == SIZE_32 && (cp ? !fs[k] : p == 8'h00))) v = tv(1, ch, r);
    else v = tv(2, ch, p);
    o = ov[k] & om;
    if (o != 2'h0) v = tv(3, ch, 8'(o - 2'h1));
    if (dc[DC_SIX_BIT]) v &= SIX_BIT_MASK;
    v = dc[4:3] == INT_ZERO ? 8'h00 : v >> dc[4:3];
    return (sy[0] && k < mx) ? v : 8'h00;
  endfunction

  // ==========================================================================
  // Pixel stimulus and DAC comparison
  task automatic put(input logic [7:0] b, input logic [7:0] st);
    @(posedge pclk);
    for (int i = 0; i < PORTS; i++) pix[i] <= b + st * 8'(i);
    for (int k = 0; k < SLOTS; k++) begin
      ov[k] <= 2'(k);
      fs[k] <= k[0];
    end
  endtask
  // Six edges cover the three-edge pin-to-DAC path with margin
  task automatic chk_pix();
    repeat (6) @(posedge pclk);
    for (int k = 0; k < SLOTS; k++) begin
      `CHK(dac_red[k], mdl(CH_R, k))
      `CHK(dac_green[k], mdl(CH_G, k))
      `CHK(dac_blue[k], mdl(CH_B, k))
    end
    `CHK(dot_valid, 5'((1 << mx) - 1))
    `CHK(dot_mux_factor, mx)
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc({4'h0, A_MODE}, {27'h0, MODE_RST}, 1'b0);
    rdc({4'h0, A_PMASK}, 32'h0000_00FF, 1'b0);
    rdc({4'h0, A_OMASK}, 32'h0000_0000, 1'b0);
    rdc(16'h0030, 32'h0000_0000, 1'b1);
    for (int ch = 0; ch < CHANS; ch++) begin
      for (int i = 0; i < TAB_DEPTH; i++) begin
        wr(ta(1, ch, i), tv(1, ch, 8'(i)));
        wr(ta(2, ch, i), tv(2, ch, 8'(i)));
        if (i < OVL_DEPTH) wr(ta(3, ch, i), tv(3, ch, 8'(i)));
      end
    end
    rdc(ta(1, 1, 5), {24'h0, tv(1, 1, 8'h05)}, 1'b0);
    rdc(ta(2, 2, 200), {24'h0, tv(2, 2, 8'hC8)}, 1'b0);
    rdc(ta(3, 0, 2), {24'h0, tv(3, 0, 8'h02)}, 1'b0);
    rdc(ta(3, 0, 3), 32'h0000_0000, 1'b1);
    pm = 8'h0F;
    cfg();
    put(8'h10, 8'h07);
    chk_pix();
    sz = SIZE_16;
    mx = 3'h3;
    cfg();
    put(8'hA5, 8'h3C);
    chk_pix();
    sz = SIZE_32;
    mx = 3'h5;
    pm = 8'hF0;
    cfg();
    put(8'h00, 8'h0B);
    chk_pix();
    cp = 1'b1;
    cfg();
    chk_pix();
    om = 2'h3;
    cfg();
    chk_pix();
    om = 2'h2;
    cfg();
    chk_pix();
    for (int d = 0; d < 4; d++) begin
      dc = {2'(d), 1'(d), 2'h0};
      cfg();
      chk_pix();
    end
    dc = 5'h03;
    cfg();
    @(posedge pclk);
    sy <= 3'h2;
    chk_pix();
    `CHK(sync_ped_off, 1'b1)
    `CHK(blank_ped_off, 1'b1)
    @(posedge pclk);
    sy <= 3'h6;
    chk_pix();
    `CHK(sync_ped_off, 1'b0)
    // Checksum frame: at least 749 per clock, so 24000 clocks wrap 24 bits
    dc = 5'h00;
    om = 2'h0;
    pm = 8'hFF;
    cfg();
    put(8'hFF, 8'h01);
    @(posedge pclk);
    sy <= 3'h7;
    @(posedge pclk);
    for (int ch = 0; ch < CHANS; ch++) begin
      s[ch] = 0;
      for (int k = 0; k < SLOTS; k++) s[ch] += int'(mdl(ch, k));
    end
    @(posedge pclk);
    sy <= 3'h4;
    repeat (6) @(posedge pclk);
    sy <= 3'h6;
    repeat (6) @(posedge pclk);
    for (int ch = 0; ch < CHANS; ch++) rdc({4'h0, A_CKSUM_R} + 16'(4 * ch),
      32'h0, 1'b0);
    @(posedge pclk);
    sy <= 3'h7;
    repeat (24000) @(posedge pclk);
    sy <= 3'h6;
    repeat (6) @(posedge pclk);
    for (int ch = 0; ch < CHANS; ch++) rdc({4'h0, A_CKSUM_R} + 16'(4 * ch),
      {8'h00, 24'(s[ch] * 24000)}, 1'b0);
    rdc({4'h0, A_STATUS}, 32'h0000_0006, 1'b0);
    finish_test();
  end
endmodule

`default_nettype wire
